/* inc/azio_pkg.sv */
// What this block does
// - Six undefined op codes set invalid-operation bit.
// - Storage parity error sets bit 1, broadcast.
// - Protect violation sets bit 2, broadcast.
// - Channel address check sets bit 3, broadcast.
// - Sense-interrupt clears the internal error bits.
// - Timer interrupts ORed onto assigned level, bit.
// - Console interrupt cleared only by sense-device bit15.
// - Matching level gates assigned bit into word.
// - Internal error blocks levels, reports its word.
// - Sense commands finish in the data cycle.
// - Respond only to area code 00000, except sense-interrupt.
// - Function 111 selects sense-device.
// - Modifier 001/010/011/110 choose sensed source.
// - Modifier bit 15 clears sensed indicators.
// - Console status word bit 0 is indicator.
// - Timer status word bits 0-2 are timers.
// - Function 100 selects control with data word.
// - Control modifier selects exactly one target.
// - Address bits 0-2 start or stop timers.
// - Mask writes 0-13 or 14-23 by bit 15.
// - Programmed interrupt sets levels by bit 15.
// - Monitor reloads only when bit 15 set.
// - Control modifier 101 selects level register.
// - Mask turning on clears pending level.
// - Programmed interrupt sets only unmasked levels.
package azio_pkg;
    localparam int       NUM_LEVELS     = 24;
    localparam int       HALF_LEVELS    = 14;
    localparam logic [4:0] AREA_INTERNAL = 5'h00;
    localparam logic [2:0] FN_SENSE_INT  = 3'h3;
    localparam logic [2:0] FN_SENSE_DEV  = 3'h7;
    localparam logic [2:0] FN_CONTROL    = 3'h4;
    localparam logic [2:0] SD_TIMER      = 3'h1;
    localparam logic [2:0] SD_DATA_SW    = 3'h2;
    localparam logic [2:0] SD_SENSE_SW   = 3'h3;
    localparam logic [2:0] SD_CONSOLE    = 3'h6;
    localparam logic [2:0] CT_TIMER      = 3'h1;
    localparam logic [2:0] CT_MASK       = 3'h4;
    localparam logic [2:0] CT_LEVEL      = 3'h5;
    localparam logic [2:0] CT_OPMON      = 3'h7;
    localparam int       ERR_INV_BIT    = 0;
    localparam int       ERR_PAR_BIT    = 1;
    localparam int       ERR_PROT_BIT   = 2;
    localparam int       ERR_CAR_BIT    = 3;
    localparam int       CON_IND_BIT    = 0;
    localparam int       CLK_PERIOD_NS  = 10;
    localparam int       TIMER_PERIOD_NS = 1000000;
    localparam int       OPMON_PERIOD_NS = 5000000;
    localparam int       TIMER_CYCLES_DEF = TIMER_PERIOD_NS / CLK_PERIOD_NS;
    localparam int       OPMON_CYCLES_DEF = OPMON_PERIOD_NS / CLK_PERIOD_NS;
    localparam logic [0:15] WORD_RESET  = 16'h0000;
    localparam logic [0:23] LEVEL_RESET = 24'h00_0000;
endpackage

/* logic/azio_ctrl.sv */
`timescale 1ns/1ns
module azio_ctrl
    import azio_pkg::*;
#(
    parameter int TMR_A_CYCLES = TIMER_CYCLES_DEF,
    parameter int TMR_B_CYCLES = TIMER_CYCLES_DEF,
    parameter int TMR_C_CYCLES = TIMER_CYCLES_DEF,
    parameter int OPMON_CYCLES = OPMON_CYCLES_DEF
) (
    input  wire logic        CLK,
    input  wire logic        RSTN,
    input  wire logic [0:15] OUT_BUS,
    input  wire logic        CONTROL_EXECUTE_CYCLE,
    input  wire logic        DATA_EXECUTE_CYCLE,
    input  wire logic        OP_DECODE,
    input  wire logic [0:4]  OP_FIELD,
    input  wire logic        PARITY_ERROR,
    input  wire logic        PROTECT_VIOLATION,
    input  wire logic        CHANNEL_ADDRESS_CHECK,
    input  wire logic        CONSOLE_KEY,
    input  wire logic [0:15] DATA_SWITCHES,
    input  wire logic [0:15] SENSE_SWITCHES,
    input  wire logic [4:0]  TIMER_LEVEL,
    input  wire logic [3:0]  TIMER_BIT,
    input  wire logic [4:0]  CONSOLE_LEVEL,
    input  wire logic [3:0]  CONSOLE_BIT,
    input  wire logic [4:0]  ACTIVE_LEVEL,
    input  wire logic [0:15] MERGE_BITS,
    input  wire logic [0:23] LEVEL_CLEAR,
    output logic      [0:15] ACC_WORD,
    output logic             ACC_VALID,
    output logic      [0:23] LEVEL_REQUEST,
    output logic             INTERNAL_REQUEST,
    output logic             IO_PARITY_LINE,
    output logic             IO_PROTECT_LINE,
    output logic      [0:2]  TIMER_RUNNING,
    output logic             OPMON_EXPIRED
);

    function automatic logic op_undefined(input logic [0:4] op);
        return (op == 5'h00) || (op == 5'h07) || (op == 5'h0A) ||
               (op == 5'h0B) || (op == 5'h0F) || (op == 5'h1F);
    endfunction

    function automatic logic [0:23] level_hot(input logic [4:0] lvl, input logic en);
        logic [0:23] v;
        v = LEVEL_RESET;
        for (int i = 0; i < NUM_LEVELS; i++) begin
            if (en && (lvl == 5'(i))) begin
                v[i] = 1'b1;
            end
        end
        return v;
    endfunction

    function automatic logic [0:15] bit_hot(input logic [3:0] pos, input logic en);
        logic [0:15] v;
        v = WORD_RESET;
        v[pos] = en;
        return v;
    endfunction

    // Command word registered during the control execute cycle.
    logic [0:15] cmd_q;
    logic        cmd_valid_q;

    logic [0:3]  err_q;
    logic [0:3]  err_d;
    logic        con_ind_q;
    logic [0:2]  tmr_ind_q;
    logic [0:2]  tmr_run_q;
    logic [0:2]  tmr_exp;
    logic [31:0] tmr_cnt_q [0:2];
    logic [0:23] mask_q;
    logic [0:23] mask_d;
    logic [0:23] pend_q;
    logic [31:0] opmon_cnt_q;

    logic [0:15] acc_word_q;
    logic        acc_valid_q;
    logic [0:23] level_req_q;
    logic        internal_req_q;
    logic        io_par_q;
    logic        io_prot_q;
    logic        opmon_exp_q;

    logic        ours;
    logic        do_sense_int;
    logic        do_sense_dev;
    logic        do_control;
    logic [2:0]  modsel;
    logic        bit15;
    logic        clr_tmr_ind;
    logic        clr_con_ind;
    logic [0:23] prog_sel;
    logic [0:23] hw_req;
    logic [0:15] int_word;
    logic [0:15] dev_word;

    always_ff @(posedge CLK) begin
        if (!RSTN) begin
            cmd_q       <= WORD_RESET;
            cmd_valid_q <= 1'b0;
        end else if (CONTROL_EXECUTE_CYCLE) begin
            cmd_q       <= OUT_BUS;
            cmd_valid_q <= 1'b1;
        end else if (DATA_EXECUTE_CYCLE) begin
            cmd_valid_q <= 1'b0;
        end
    end

    // Only the internal area answers sense-device and control; other areas pass unseen.
    assign ours         = cmd_valid_q && DATA_EXECUTE_CYCLE && (cmd_q[0:4] == AREA_INTERNAL);
    // Sense-interrupt carries a level address, not an area, so it is taken from any area.
    assign do_sense_int = cmd_valid_q && DATA_EXECUTE_CYCLE && (cmd_q[5:7] == FN_SENSE_INT);
    assign do_sense_dev = ours && (cmd_q[5:7] == FN_SENSE_DEV);
    assign do_control   = ours && (cmd_q[5:7] == FN_CONTROL);
    assign modsel       = cmd_q[8:10];
    assign bit15        = cmd_q[15];

    assign clr_tmr_ind = do_sense_dev && (modsel == SD_TIMER) && bit15;
    assign clr_con_ind = do_sense_dev && (modsel == SD_CONSOLE) && bit15;

    // New errors win over the clear that sense-interrupt performs.
    always_comb begin
        err_d = err_q;
        if (do_sense_int && internal_req_q) begin
            err_d = 4'h0;
        end
        if (OP_DECODE && op_undefined(OP_FIELD)) begin
            err_d[ERR_INV_BIT] = 1'b1;
        end
        if (PARITY_ERROR) begin
            err_d[ERR_PAR_BIT] = 1'b1;
        end
        if (PROTECT_VIOLATION) begin
            err_d[ERR_PROT_BIT] = 1'b1;
        end
        if (CHANNEL_ADDRESS_CHECK) begin
            err_d[ERR_CAR_BIT] = 1'b1;
        end
    end

    always_ff @(posedge CLK) begin
        if (!RSTN) begin
            err_q <= 4'h0;
        end else begin
            err_q <= err_d;
        end
    end

    // Broadcast is one clock behind the detection, as every output is registered.
    always_ff @(posedge CLK) begin
        if (!RSTN) begin
            io_par_q  <= 1'b0;
            io_prot_q <= 1'b0;
        end else begin
            io_par_q  <= PARITY_ERROR | CHANNEL_ADDRESS_CHECK;
            io_prot_q <= PROTECT_VIOLATION;
        end
    end

    always_ff @(posedge CLK) begin
        if (!RSTN) begin
            con_ind_q <= 1'b0;
        end else if (CONSOLE_KEY) begin
            con_ind_q <= 1'b1;
        end else if (clr_con_ind) begin
            con_ind_q <= 1'b0;
        end
    end

    always_ff @(posedge CLK) begin
        if (!RSTN) begin
            tmr_run_q <= 3'h0;
        end else if (do_control && (modsel == CT_TIMER)) begin
            tmr_run_q <= OUT_BUS[0:2];
        end
    end

    // A stopped timer restarts its interval from zero.
    always_ff @(posedge CLK) begin
        if (!RSTN) begin
            for (int t = 0; t < 3; t++) begin
                tmr_cnt_q[t] <= 32'h0000_0000;
            end
        end else begin
            for (int t = 0; t < 3; t++) begin
                if (!tmr_run_q[t] || tmr_exp[t]) begin
                    tmr_cnt_q[t] <= 32'h0000_0000;
                end else begin
                    tmr_cnt_q[t] <= tmr_cnt_q[t] + 32'h0000_0001;
                end
            end
        end
    end

    assign tmr_exp[0] = tmr_run_q[0] && (tmr_cnt_q[0] == 32'(TMR_A_CYCLES - 1));
    assign tmr_exp[1] = tmr_run_q[1] && (tmr_cnt_q[1] == 32'(TMR_B_CYCLES - 1));
    assign tmr_exp[2] = tmr_run_q[2] && (tmr_cnt_q[2] == 32'(TMR_C_CYCLES - 1));

    always_ff @(posedge CLK) begin
        if (!RSTN) begin
            tmr_ind_q <= 3'h0;
        end else begin
            tmr_ind_q <= (tmr_ind_q & ~{3{clr_tmr_ind}}) | tmr_exp;
        end
    end

    // Mask register write; a half not addressed keeps its value.
    always_comb begin
        mask_d = mask_q;
        if (do_control && (modsel == CT_MASK)) begin
            if (!bit15) begin
                mask_d[0:13] = OUT_BUS[0:13];
            end else begin
                mask_d[14:23] = OUT_BUS[0:9];
            end
        end
    end

    always_ff @(posedge CLK) begin
        if (!RSTN) begin
            mask_q <= LEVEL_RESET;
        end else begin
            mask_q <= mask_d;
        end
    end

    always_comb begin
        prog_sel = LEVEL_RESET;
        if (do_control && (modsel == CT_LEVEL)) begin
            if (!bit15) begin
                prog_sel[0:13] = OUT_BUS[0:13];
            end else begin
                prog_sel[14:23] = OUT_BUS[0:9];
            end
        end
    end

    // Service completion clears first, then a programmed set wins.
    always_ff @(posedge CLK) begin
        if (!RSTN) begin
            pend_q <= LEVEL_RESET;
        end else begin
            pend_q <= ((pend_q & ~LEVEL_CLEAR) & ~(mask_d & ~mask_q))
                      | (prog_sel & ~mask_q);
        end
    end

    // Reload is the only effect; the address word is not looked at.
    always_ff @(posedge CLK) begin
        if (!RSTN) begin
            opmon_cnt_q <= 32'(OPMON_CYCLES);
            opmon_exp_q <= 1'b0;
        end else if (do_control && (modsel == CT_OPMON) && bit15) begin
            opmon_cnt_q <= 32'(OPMON_CYCLES);
            opmon_exp_q <= 1'b0;
        end else if (opmon_cnt_q != 32'h0000_0000) begin
            opmon_cnt_q <= opmon_cnt_q - 32'h0000_0001;
        end else begin
            opmon_exp_q <= 1'b1;
        end
    end

    assign hw_req = level_hot(TIMER_LEVEL, |tmr_ind_q)
                  | level_hot(CONSOLE_LEVEL, con_ind_q);

    always_ff @(posedge CLK) begin
        if (!RSTN) begin
            level_req_q    <= LEVEL_RESET;
            internal_req_q <= 1'b0;
        end else begin
            internal_req_q <= |err_d;
            // The internal level blocks every other level while active.
            level_req_q    <= (|err_d) ? LEVEL_RESET : ((pend_q | hw_req) & ~mask_q);
        end
    end

    always_comb begin
        int_word = MERGE_BITS;
        if (internal_req_q) begin
            int_word = {err_q, 12'h000};
        end else begin
            if ((|tmr_ind_q) && (TIMER_LEVEL == ACTIVE_LEVEL)) begin
                int_word = int_word | bit_hot(TIMER_BIT, 1'b1);
            end
            if (con_ind_q && (CONSOLE_LEVEL == ACTIVE_LEVEL)) begin
                int_word = int_word | bit_hot(CONSOLE_BIT, 1'b1);
            end
        end
    end

    always_comb begin
        case (modsel)
            SD_TIMER:    dev_word = {tmr_ind_q, 13'h0000};
            SD_DATA_SW:  dev_word = DATA_SWITCHES;
            SD_SENSE_SW: dev_word = SENSE_SWITCHES;
            SD_CONSOLE:  dev_word = bit_hot(4'(CON_IND_BIT), con_ind_q);
            default:     dev_word = WORD_RESET;
        endcase
    end

    // The answer is ready the clock after the data cycle; no third cycle is needed.
    always_ff @(posedge CLK) begin
        if (!RSTN) begin
            acc_word_q  <= WORD_RESET;
            acc_valid_q <= 1'b0;
        end else begin
            acc_valid_q <= do_sense_int | do_sense_dev;
            if (do_sense_int) begin
                acc_word_q <= int_word;
            end else if (do_sense_dev) begin
                acc_word_q <= dev_word;
            end
        end
    end

    assign ACC_WORD         = acc_word_q;
    assign ACC_VALID        = acc_valid_q;
    assign LEVEL_REQUEST    = level_req_q;
    assign INTERNAL_REQUEST = internal_req_q;
    assign IO_PARITY_LINE   = io_par_q;
    assign IO_PROTECT_LINE  = io_prot_q;
    assign TIMER_RUNNING    = tmr_run_q;
    assign OPMON_EXPIRED    = opmon_exp_q;

    default clocking cb @(posedge CLK); endclocking
    default disable iff (!RSTN);

    invalid_op_a: assert property (OP_DECODE && op_undefined(OP_FIELD) |=> err_q[0])
        else $error("undefined op code did not set invalid bit");
    parity_bcast_a: assert property ((PARITY_ERROR || CHANNEL_ADDRESS_CHECK) |=> IO_PARITY_LINE)
        else $error("parity line not raised");
    protect_set_a: assert property (PROTECT_VIOLATION |=> err_q[2] && IO_PROTECT_LINE)
        else $error("protect violation not recorded");
    car_set_a: assert property (CHANNEL_ADDRESS_CHECK |=> err_q[3])
        else $error("channel address check not recorded");
    err_clear_a: assert property (do_sense_int && internal_req_q && !OP_DECODE && !PARITY_ERROR
        && !PROTECT_VIOLATION && !CHANNEL_ADDRESS_CHECK |=> err_q == 4'h0)
        else $error("sense-interrupt left error bits set");
    console_hold_a: assert property (con_ind_q && !clr_con_ind |=> con_ind_q)
        else $error("console indicator lost without sense-device");
    internal_block_a: assert property (INTERNAL_REQUEST |-> LEVEL_REQUEST == LEVEL_RESET)
        else $error("levels requested during internal error");
    sense_answer_a: assert property ((do_sense_int || do_sense_dev) |=> ACC_VALID ##1 !ACC_VALID)
        else $error("sense answer not a single pulse next cycle");
    other_area_a: assert property (cmd_valid_q && DATA_EXECUTE_CYCLE && cmd_q[0:4] != AREA_INTERNAL
        && cmd_q[5:7] == FN_SENSE_DEV |=> !ACC_VALID)
        else $error("answered a sense-device for another area");
    timer_clear_a: assert property (clr_tmr_ind && tmr_exp == 3'h0 |=> tmr_ind_q == 3'h0)
        else $error("timer indicators not cleared");
    timer_word_a: assert property (do_sense_dev && modsel == SD_TIMER
        |=> ACC_WORD == {$past(tmr_ind_q), 13'h0000})
        else $error("timer status word wrong");
    timer_run_a: assert property (do_control && modsel == CT_TIMER
        |=> TIMER_RUNNING == $past(OUT_BUS[0:2]))
        else $error("timer start or stop not applied");
    mask_low_a: assert property (do_control && modsel == CT_MASK && !bit15
        |=> mask_q[0:13] == $past(OUT_BUS[0:13]))
        else $error("mask low half not written");
    // The high half takes only ten address bits, so a stray bit must not leak in.
    mask_high_a: assert property (do_control && modsel == CT_MASK && bit15
        |=> mask_q[14:23] == $past(OUT_BUS[0:9]))
        else $error("mask high half not written");
    prog_masked_a: assert property (prog_sel[14] && mask_q[14] && !pend_q[14] |=> !pend_q[14])
        else $error("masked level set by programmed interrupt");
    mask_clear_a: assert property (mask_d[0] && !mask_q[0] |=> !pend_q[0])
        else $error("pending level kept when mask turned on");
    opmon_reload_a: assert property (do_control && modsel == CT_OPMON && bit15
        |=> opmon_cnt_q == 32'(OPMON_CYCLES) && !OPMON_EXPIRED)
        else $error("operations monitor not reloaded");

endmodule

/* test/azio_seq_model.sv */
`timescale 1ns/1ns
// Instruction sequencer side: issues one command pair and takes the answer.
module azio_seq_model (
    input  wire logic        CLK,
    input  wire logic [0:15] ACC_WORD,
    input  wire logic        ACC_VALID,
    output logic      [0:15] OUT_BUS,
    output logic             CONTROL_EXECUTE_CYCLE,
    output logic             DATA_EXECUTE_CYCLE
);
    initial begin
        OUT_BUS = 16'h0000;
        CONTROL_EXECUTE_CYCLE = 1'b0;
        DATA_EXECUTE_CYCLE = 1'b0;
    end

    // The bus shows the inverse of the last word once released, so a stale value never matches.
    task automatic xio(input logic [0:15] cmd, input logic [0:15] adr,
                       output logic v, output logic [0:15] acc);
        @(posedge CLK);
        CONTROL_EXECUTE_CYCLE <= 1'b1;
        OUT_BUS <= cmd;
        @(posedge CLK);
        CONTROL_EXECUTE_CYCLE <= 1'b0;
        DATA_EXECUTE_CYCLE <= 1'b1;
        OUT_BUS <= adr;
        @(posedge CLK);
        DATA_EXECUTE_CYCLE <= 1'b0;
        OUT_BUS <= ~adr;
        #1;
        v = ACC_VALID;
        acc = ACC_WORD;
    endtask
endmodule

/* test/internal_area_zero_io_control_tb_top.sv */
`timescale 1ns/1ns
module internal_area_zero_io_control_tb_top;
    logic        clk, rst_n, op_decode, par_err, prot_err, chan_err, console_key;
    logic [0:4]  op_field;
    logic [0:15] out_bus, data_sw, sense_sw, merge_bits, acc_word;
    logic [4:0]  active_level, timer_level, console_level;
    logic [3:0]  timer_bit, console_bit;
    logic [0:23] level_clear, level_request;
    logic        ctrl_cyc, data_cyc, acc_valid, internal_request, io_parity, io_protect;
    logic        opmon_expired;
    logic [0:2]  timer_running;
    logic        v;
    logic [0:15] acc;
    logic [0:4]  codes [7] = '{5'h00, 5'h07, 5'h0A, 5'h0B, 5'h0F, 5'h1F, 5'h01};
    int          n_mismatch, comparisons;

    azio_ctrl #(.TMR_A_CYCLES(8), .TMR_B_CYCLES(20), .TMR_C_CYCLES(20), .OPMON_CYCLES(20))
    azio_ctrl_i (
        .CLK(clk), .RSTN(rst_n), .OUT_BUS(out_bus),
        .CONTROL_EXECUTE_CYCLE(ctrl_cyc), .DATA_EXECUTE_CYCLE(data_cyc),
        .OP_DECODE(op_decode), .OP_FIELD(op_field), .PARITY_ERROR(par_err),
        .PROTECT_VIOLATION(prot_err), .CHANNEL_ADDRESS_CHECK(chan_err),
        .CONSOLE_KEY(console_key), .DATA_SWITCHES(data_sw), .SENSE_SWITCHES(sense_sw),
        .TIMER_LEVEL(timer_level), .TIMER_BIT(timer_bit), .CONSOLE_LEVEL(console_level),
        .CONSOLE_BIT(console_bit),
        .ACTIVE_LEVEL(active_level), .MERGE_BITS(merge_bits), .LEVEL_CLEAR(level_clear),
        .ACC_WORD(acc_word), .ACC_VALID(acc_valid), .LEVEL_REQUEST(level_request),
        .INTERNAL_REQUEST(internal_request), .IO_PARITY_LINE(io_parity),
        .IO_PROTECT_LINE(io_protect), .TIMER_RUNNING(timer_running),
        .OPMON_EXPIRED(opmon_expired)
    );

    azio_seq_model azio_seq_model_i (
        .CLK(clk), .ACC_WORD(acc_word), .ACC_VALID(acc_valid), .OUT_BUS(out_bus),
        .CONTROL_EXECUTE_CYCLE(ctrl_cyc), .DATA_EXECUTE_CYCLE(data_cyc)
    );

    initial begin
        clk = 1'b0;
        forever #5 clk = ~clk;
    end

    task automatic check(input logic [23:0] got, input logic [23:0] exp);
        comparisons++;
        if (got !== exp) begin
            n_mismatch++;
            $display("[ERR] t=%0t got=%h exp=%h", $time, got, exp);
        end
    endtask

    // A sense command must answer with a valid word in the cycle after its data cycle.
    task automatic sense(input logic [0:15] cmd, input logic [0:15] exp);
        azio_seq_model_i.xio(cmd, 16'h0000, v, acc);
        check(24'({v, acc}), 24'({1'b1, exp}));
    endtask

    task automatic ctl(input logic [0:15] cmd, input logic [0:15] adr);
        azio_seq_model_i.xio(cmd, adr, v, acc);
    endtask

    task automatic lvl(input logic [0:23] exp);
        @(posedge clk);
        #1;
        check(level_request, exp);
    endtask

    task automatic finish_test();
        if (n_mismatch == 0 && comparisons > 0) begin
            $display("STATUS OK");
        end else begin
            $display("STATUS NOT OK");
        end
        $finish;
    endtask

    initial begin
        n_mismatch = 0;
        comparisons = 0;
        rst_n = 1'b0;
        {op_decode, par_err, prot_err, chan_err, console_key} = 5'h00;
        op_field = 5'h01;
        data_sw = 16'hA5C3;
        sense_sw = 16'h3C5A;
        merge_bits = 16'h0000;
        active_level = 5'h00;
        timer_level = 5'h05;
        timer_bit = 4'h3;
        console_level = 5'h14;
        console_bit = 4'h9;
        level_clear = 24'h00_0000;
        repeat (16) @(posedge clk);
        rst_n <= 1'b1;
        lvl(24'h00_0000);
        check(24'({internal_request, io_parity, io_protect, timer_running}), 24'h00_0000);
        // Timer A alone, short period; stopped before a second expiry.
        ctl(16'h0420, 16'h8000);
        check(24'(timer_running), 24'h00_0004);
        repeat (10) @(posedge clk);
        ctl(16'h0420, 16'h0000);
        check(24'(timer_running), 24'h00_0000);
        lvl(24'h04_0000);
        active_level <= 5'h05;
        merge_bits <= 16'h0001;
        sense(16'h0300, 16'h1001);
        // Moving the timer to another level must move its request and drop its word bit.
        timer_level <= 5'h06;
        lvl(24'h02_0000);
        sense(16'h0300, 16'h0001);
        sense(16'h0720, 16'h8000);
        sense(16'h0721, 16'h8000);
        sense(16'h0720, 16'h0000);
        // Console indicator survives sense-interrupt and plain sensing.
        @(posedge clk) console_key <= 1'b1;
        @(posedge clk) console_key <= 1'b0;
        active_level <= 5'h14;
        merge_bits <= 16'h0000;
        sense(16'h0300, 16'h0040);
        sense(16'h0300, 16'h0040);
        console_bit <= 4'h0;
        sense(16'h0300, 16'h8000);
        console_level <= 5'h13;
        sense(16'h0300, 16'h0000);
        console_level <= 5'h14;
        sense(16'h07C0, 16'h8000);
        sense(16'h07C1, 16'h8000);
        sense(16'h07C0, 16'h0000);
        sense(16'h0740, 16'hA5C3);
        sense(16'h0760, 16'h3C5A);
        data_sw <= 16'h5A3C;
        sense_sw <= 16'hC3A5;
        sense(16'h0740, 16'h5A3C);
        sense(16'h0760, 16'hC3A5);
        azio_seq_model_i.xio(16'h8740, 16'h0000, v, acc);
        check(24'(v), 24'h00_0000);
        // Mask and programmed levels, both halves.
        ctl(16'h04A0, 16'hC000);
        lvl(24'hC0_0000);
        ctl(16'h0480, 16'h8000);
        lvl(24'h40_0000);
        ctl(16'h0480, 16'h0000);
        lvl(24'h40_0000);
        ctl(16'h0481, 16'hFFC0);
        ctl(16'h04A1, 16'hFFC0);
        ctl(16'h0481, 16'h0000);
        lvl(24'h40_0000);
        ctl(16'h04A1, 16'h8000);
        lvl(24'h40_0200);
        @(posedge clk) level_clear <= 24'hFF_FFFF;
        @(posedge clk) level_clear <= 24'h00_0000;
        ctl(16'h04A0, 16'h0004);
        lvl(24'h00_0400);
        // Op codes: six undefined ones, then a defined one after the error was reported.
        active_level <= 5'h00;
        for (int i = 0; i < 7; i++) begin
            @(posedge clk);
            op_decode <= 1'b1;
            op_field <= codes[i];
            @(posedge clk) op_decode <= 1'b0;
            #1;
            check(24'(internal_request), (i < 6) ? 24'h00_0001 : 24'h00_0000);
            lvl((i < 6) ? 24'h00_0000 : 24'h00_0400);
            sense(16'h0300, (i < 6) ? 16'h8000 : 16'h0000);
        end
        // Parity, protect and channel address checks, with their broadcast lines.
        for (int j = 0; j < 3; j++) begin
            @(posedge clk) {par_err, prot_err, chan_err} <= 3'h4 >> j;
            @(posedge clk) {par_err, prot_err, chan_err} <= 3'h0;
            #1;
            check(24'({io_parity, io_protect}), (j == 1) ? 24'h00_0001 : 24'h00_0002);
            sense(16'h0300, 16'h4000 >> j);
        end
        // Operations monitor has run out long ago; only bit 15 reloads it.
        check(24'(opmon_expired), 24'h00_0001);
        ctl(16'h04E0, 16'hFFFF);
        check(24'(opmon_expired), 24'h00_0001);
        ctl(16'h04E1, 16'h0000);
        @(posedge clk);
        #1;
        check(24'(opmon_expired), 24'h00_0000);
        finish_test();
    end
endmodule
